/* neg_seq_overvoltage.sv */
/*
 * Two-stage negative sequence overvoltage protection with an Avalon-MM
 * register slave. Assumes phasor samples synchronous to mclk and a
 * master that holds each request until waitrequest is low.
 */
`timescale 1ns/100ps
module neg_seq_overvoltage #(
    parameter int TICK_CYCLES = nsov_pkg::TICK_CYCLES
) (
    input wire logic mclk, // system clock
    input wire logic reset_n, // synchronous reset
    input wire logic [3:0] address, // word address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [31:0] writedata, // write data
    input wire logic [3:0] byteenable, // write lanes
    output logic [31:0] readdata, // read data
    output logic waitrequest, // slave stall
    input wire logic signed [15:0] phase_a_re, // phase a phasor
    input wire logic signed [15:0] phase_a_im,
    input wire logic signed [15:0] phase_b_re, // phase b phasor
    input wire logic signed [15:0] phase_b_im,
    input wire logic signed [15:0] phase_c_re, // phase c, unused phase-phase
    input wire logic signed [15:0] phase_c_im,
    input wire logic [3:0] general_inhibit, // blocks both stages
    input wire logic [1:0] first_stage_inhibit, // blocks stage one
    input wire logic [1:0] second_stage_inhibit, // blocks stage two
    input wire logic [1:0] single_pole_open_inhibit, // open pole
    input wire logic [1:0] measuring_circuit_fault, // vt failure
    output logic [1:0] stage_start_flag, // pickup per stage
    output logic [1:0] stage_trip_flag, // trip per stage
    output logic [1:0] stage_inhibited_flag, // blocked per stage
    output logic [3:0] stage_operating_mode, // mode_t per stage
    output logic health_alarm // configuration alarm
);

    ////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction

    // one component of (x + a2*y + a*z)/3, d carries the quadrature cross term
    function automatic logic signed [19:0] seq_part(input logic signed [17:0] x,
        input logic signed [17:0] y, input logic signed [17:0] z,
        input logic signed [17:0] d);
        logic signed [39:0] acc;
        acc = (40'(x) <<< 16) - ((40'(y) + 40'(z)) <<< 15)
            + 40'(d) * $signed({1'b0, nsov_pkg::SEQ_K});
        return 20'((acc / 40'sd3) >>> 16);
    endfunction

    function automatic logic [19:0] isqrt(input logic [39:0] v);
        logic [19:0] r;
        logic [19:0] c;
        r = '0;
        for (int i = 19; i >= 0; i--) begin
            c = r | (20'h1 << i);
            if (40'(c) * 40'(c) <= v) r = c;
        end
        return r;
    endfunction

    function automatic logic [19:0] uop_of(input logic [11:0] thr, input logic [15:0] ur);
        logic [43:0] p;
        p = 44'(thr) * 44'(ur) * 44'(nsov_pkg::UOP_K);
        return 20'(p >> nsov_pkg::UOP_SHIFT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file over avalon
    logic [31:0] ctrl_reg, rated_reg, tms_reg;
    logic [31:0] thr_reg [2];
    logic [31:0] dly_reg [2];
    logic [19:0] mag;
    logic wr_go;
    logic [31:0] next_readdata;
    logic [1:0] stage_enable;
    logic second_stage_curve_select;
    logic [11:0] stage_threshold [2];
    logic [18:0] stage_definite_delay [2];
    logic [10:0] inverse_time_multiplier;
    nsov_pkg::chan_cfg_t cfg;

    assign wr_go = write && !waitrequest;
    assign stage_enable = ctrl_reg[nsov_pkg::CTRL_EN_LSB +: 2];
    assign second_stage_curve_select = ctrl_reg[nsov_pkg::CTRL_CURVE_BIT];
    assign cfg = nsov_pkg::chan_cfg_t'(ctrl_reg[nsov_pkg::CTRL_CFG_LSB +: 2]);
    assign inverse_time_multiplier = tms_reg[10:0];
    assign stage_threshold[0] = thr_reg[0][11:0];
    assign stage_threshold[1] = thr_reg[1][11:0];
    assign stage_definite_delay[0] = dly_reg[0][18:0];
    assign stage_definite_delay[1] = dly_reg[1][18:0];

    // one wait cycle per access keeps readdata a flop
    always_ff @(posedge mclk) begin
        if (!reset_n) waitrequest <= 1'b1;
        else waitrequest <= !((read || write) && waitrequest);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_reg <= nsov_pkg::CTRL_RESET;
            rated_reg <= nsov_pkg::RATED_RESET;
            thr_reg[0] <= nsov_pkg::THR_RESET;
            thr_reg[1] <= nsov_pkg::THR_RESET;
            dly_reg[0] <= nsov_pkg::DLY_RESET;
            dly_reg[1] <= nsov_pkg::DLY_RESET;
            tms_reg <= nsov_pkg::TMS_RESET;
        end else if (wr_go) begin
            case (address)
                nsov_pkg::REG_CTRL: ctrl_reg <= merge(ctrl_reg, writedata, byteenable)
                    & nsov_pkg::CTRL_MASK;
                nsov_pkg::REG_RATED: rated_reg <= merge(rated_reg, writedata, byteenable)
                    & nsov_pkg::RATED_MASK;
                nsov_pkg::REG_THR1: thr_reg[0] <= merge(thr_reg[0], writedata, byteenable)
                    & nsov_pkg::THR_MASK;
                nsov_pkg::REG_THR2: thr_reg[1] <= merge(thr_reg[1], writedata, byteenable)
                    & nsov_pkg::THR_MASK;
                nsov_pkg::REG_DLY1: dly_reg[0] <= merge(dly_reg[0], writedata, byteenable)
                    & nsov_pkg::DLY_MASK;
                nsov_pkg::REG_DLY2: dly_reg[1] <= merge(dly_reg[1], writedata, byteenable)
                    & nsov_pkg::DLY_MASK;
                nsov_pkg::REG_TMS: tms_reg <= merge(tms_reg, writedata, byteenable)
                    & nsov_pkg::TMS_MASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            nsov_pkg::REG_CTRL: next_readdata = ctrl_reg;
            nsov_pkg::REG_RATED: next_readdata = rated_reg;
            nsov_pkg::REG_THR1: next_readdata = thr_reg[0];
            nsov_pkg::REG_THR2: next_readdata = thr_reg[1];
            nsov_pkg::REG_DLY1: next_readdata = dly_reg[0];
            nsov_pkg::REG_DLY2: next_readdata = dly_reg[1];
            nsov_pkg::REG_TMS: next_readdata = tms_reg;
            nsov_pkg::REG_STATUS: begin
                next_readdata[nsov_pkg::STAT_START_LSB +: 2] = stage_start_flag;
                next_readdata[nsov_pkg::STAT_TRIP_LSB +: 2] = stage_trip_flag;
                next_readdata[nsov_pkg::STAT_BLK_LSB +: 2] = stage_inhibited_flag;
                next_readdata[nsov_pkg::STAT_ALARM_BIT] = health_alarm;
            end
            nsov_pkg::REG_MAG: next_readdata = {12'h000, mag};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) readdata <= 32'h0000_0000;
        else if (read && waitrequest) readdata <= next_readdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // negative sequence magnitude, two pipeline stages
    logic signed [17:0] a_re, a_im, b_re, b_im, c_re, c_im;
    logic signed [19:0] u2_re, u2_im;
    logic pp_q;

    always_comb begin
        a_re = 18'(phase_a_re);
        a_im = 18'(phase_a_im);
        b_re = 18'(phase_b_re);
        b_im = 18'(phase_b_im);
        c_re = 18'(phase_c_re);
        c_im = 18'(phase_c_im);
        // line voltages sum to zero, so the third one is implied
        if (cfg == nsov_pkg::CFG_PHASE_PHASE) begin
            c_re = -(a_re + b_re);
            c_im = -(a_im + b_im);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            u2_re <= '0;
            u2_im <= '0;
            pp_q <= 1'b0;
            mag <= '0;
        end else begin
            u2_re <= seq_part(a_re, b_re, c_re, b_im - c_im);
            u2_im <= seq_part(a_im, b_im, c_im, c_re - b_re);
            pp_q <= (cfg == nsov_pkg::CFG_PHASE_PHASE);
            // line based sequence is root three larger than phase based
            // squares widened before the product, a 20 bit square would wrap
            if (pp_q) mag <= 20'((36'(isqrt(40'(u2_re) * 40'(u2_re)
                + 40'(u2_im) * 40'(u2_im))) * 36'(nsov_pkg::INV_SQRT3_K)) >> 16);
            else mag <= isqrt(40'(u2_re) * 40'(u2_re) + 40'(u2_im) * 40'(u2_im));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick
    logic [31:0] tick_cnt;
    logic tick;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // blocking, health and levels
    logic [1:0] blk, active, inv_v, up_v, down_v;
    logic alarm_c;
    logic [19:0] uop_v [2];
    logic [19:0] lo96 [2];
    logic [19:0] hi104 [2];
    logic [19:0] diff2;
    logic [42:0] inc2;
    logic [30:0] den2;

    always_comb begin
        alarm_c = (cfg == nsov_pkg::CFG_NONE) || (cfg == nsov_pkg::CFG_INVALID);
        blk[0] = (|general_inhibit) || (|first_stage_inhibit)
            || (|single_pole_open_inhibit) || (|measuring_circuit_fault);
        blk[1] = (|general_inhibit) || (|second_stage_inhibit)
            || (|single_pole_open_inhibit) || (|measuring_circuit_fault);
        for (int s = 0; s < 2; s++) begin
            active[s] = stage_enable[s] && !blk[s] && !alarm_c;
            inv_v[s] = (s == 1) && second_stage_curve_select;
            uop_v[s] = uop_of(stage_threshold[s], rated_reg[15:0]);
            lo96[s] = 20'((25'(uop_v[s]) * 25'(nsov_pkg::DT_RESET_NUM))
                / 25'(nsov_pkg::HYST_DEN));
            hi104[s] = 20'((25'(uop_v[s]) * 25'(nsov_pkg::INV_PICK_NUM))
                / 25'(nsov_pkg::HYST_DEN));
            up_v[s] = inv_v[s] ? (mag > hi104[s]) : (mag > uop_v[s]);
            down_v[s] = inv_v[s] ? (mag < uop_v[s]) : (mag < lo96[s]);
        end
        // per tick share of the full integral: (U-Uop)/Uop/TM over 1000 ms
        diff2 = (mag > uop_v[1]) ? mag - uop_v[1] : '0;
        den2 = 31'(uop_v[1]) * 31'(inverse_time_multiplier);
        inc2 = (den2 == '0) ? '0 : (43'(diff2) * 43'(nsov_pkg::INV_NUM)) / 43'(den2);
    end

    ////////////////////////////////////////////////////////////////////////
    // stage sequencing
    nsov_pkg::stage_state_t state [2];
    nsov_pkg::stage_state_t next_state [2];
    logic [18:0] timer [2];
    logic [18:0] next_timer [2];
    logic [43:0] acc, next_acc;

    always_comb begin
        next_acc = acc;
        for (int s = 0; s < 2; s++) begin
            next_state[s] = state[s];
            next_timer[s] = timer[s];
            case (state[s])
                nsov_pkg::ST_IDLE: begin
                    if (up_v[s]) begin
                        next_timer[s] = '0;
                        if (!inv_v[s] && stage_definite_delay[s] == '0)
                            next_state[s] = nsov_pkg::ST_TRIPPED;
                        else next_state[s] = nsov_pkg::ST_PICKED;
                    end
                end
                nsov_pkg::ST_PICKED: begin
                    if (down_v[s]) begin
                        next_state[s] = nsov_pkg::ST_IDLE;
                        next_timer[s] = '0;
                    end else if (tick && !inv_v[s]) begin
                        next_timer[s] = timer[s] + 19'h00001;
                        if (next_timer[s] >= stage_definite_delay[s])
                            next_state[s] = nsov_pkg::ST_TRIPPED;
                    end else if (tick && inv_v[s]) begin
                        next_acc = acc + 44'(inc2);
                        if (next_acc >= nsov_pkg::INV_FULL)
                            next_state[s] = nsov_pkg::ST_TRIPPED;
                    end
                end
                nsov_pkg::ST_TRIPPED: begin
                    if (down_v[s]) begin
                        next_state[s] = nsov_pkg::ST_IDLE;
                        next_timer[s] = '0;
                    end
                end
                default: next_state[s] = nsov_pkg::ST_IDLE;
            endcase
            if (!active[s]) begin
                next_state[s] = nsov_pkg::ST_IDLE;
                next_timer[s] = '0;
            end
        end
        if (next_state[1] != nsov_pkg::ST_PICKED) next_acc = '0;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            for (int s = 0; s < 2; s++) begin
                state[s] <= nsov_pkg::ST_IDLE;
                timer[s] <= '0;
            end
            acc <= '0;
            stage_start_flag <= 2'b00;
            stage_trip_flag <= 2'b00;
            stage_inhibited_flag <= 2'b00;
            stage_operating_mode <= 4'h0;
            health_alarm <= 1'b0;
        end else begin
            acc <= next_acc;
            health_alarm <= alarm_c;
            for (int s = 0; s < 2; s++) begin
                state[s] <= next_state[s];
                timer[s] <= next_timer[s];
                stage_start_flag[s] <= (next_state[s] != nsov_pkg::ST_IDLE);
                stage_trip_flag[s] <= (next_state[s] == nsov_pkg::ST_TRIPPED);
                stage_inhibited_flag[s] <= blk[s];
                if (!stage_enable[s]) stage_operating_mode[2*s +: 2] <= nsov_pkg::MODE_OFF;
                else if (blk[s] || alarm_c)
                    stage_operating_mode[2*s +: 2] <= nsov_pkg::MODE_BLOCKED;
                else stage_operating_mode[2*s +: 2] <= nsov_pkg::MODE_ON;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_disabled_quiet: assert property (!stage_enable[0] |=> !stage_start_flag[0]
        && !stage_trip_flag[0]) else $error("disabled stage one active");
    chk_general_block: assert property (|general_inhibit |=> stage_inhibited_flag == 2'b11
        && stage_start_flag == 2'b00) else $error("general inhibit not honoured");
    chk_stage_block: assert property ((|second_stage_inhibit) && !(|general_inhibit)
        && !(|first_stage_inhibit) && !(|single_pole_open_inhibit)
        && !(|measuring_circuit_fault) |=> stage_inhibited_flag == 2'b10)
        else $error("stage inhibit leaked");
    chk_open_pole: assert property (|single_pole_open_inhibit |=>
        stage_trip_flag == 2'b00) else $error("trip during open pole");
    chk_vt_fault: assert property (|measuring_circuit_fault |=>
        stage_inhibited_flag == 2'b11) else $error("vt fault did not block");
    // sampled reset keeps the release edge out of the antecedent
    chk_health_alarm: assert property (reset_n && cfg == nsov_pkg::CFG_NONE |=>
        health_alarm && stage_start_flag == 2'b00) else $error("alarm not raised");
    chk_dt_pickup: assert property (active[0] && state[0] == nsov_pkg::ST_IDLE
        && mag > uop_v[0] |=> stage_start_flag[0]) else $error("missed pickup");
    chk_dt_drop: assert property (stage_start_flag[0] && mag < lo96[0]
        |=> !stage_start_flag[0] && !stage_trip_flag[0] && timer[0] == '0)
        else $error("stage one did not drop");
    chk_zero_delay: assert property (active[0] && state[0] == nsov_pkg::ST_IDLE
        && up_v[0] && stage_definite_delay[0] == '0 |=> stage_trip_flag[0])
        else $error("zero delay not instant");
    chk_trip_with_start: assert property ($rose(stage_trip_flag[1]) |->
        stage_start_flag[1]) else $error("trip without pickup");
    chk_inv_drop: assert property (inv_v[1] && stage_start_flag[1] && mag < uop_v[1]
        |=> !stage_start_flag[1] && acc == '0) else $error("integral kept");
    chk_tick_spacing: assert property (tick |=> !tick)
        else $error("tick wider than a cycle");

endmodule // neg_seq_overvoltage

/* neg_seq_overvoltage_test.sv */
/* bench for the negative sequence overvoltage block
   assumes a 10 cycle tick; the source feeds phase-earth or line phasors */
`timescale 1ns/100ps
module neg_seq_overvoltage_test;
    logic mclk = 0, reset_n = 0, read = 0, write = 0, waitrequest, health_alarm;
    logic [3:0] address = 4'h0, general_inhibit = 4'h0, stage_operating_mode;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [15:0] level = 16'h0;
    logic line_mode = 1'b0;
    logic signed [15:0] a_re, a_im, b_re, b_im, c_re, c_im;
    logic [1:0] first_stage_inhibit = 2'h0, second_stage_inhibit = 2'h0;
    logic [1:0] single_pole_open_inhibit = 2'h0, measuring_circuit_fault = 2'h0;
    logic [1:0] stage_start_flag, stage_trip_flag, stage_inhibited_flag;
    int failures = 0, n_tests = 0;
    always #20 mclk = ~mclk;
    nseq_source i_nseq_source (.level(level), .line_mode(line_mode), .a_re(a_re),
        .a_im(a_im), .b_re(b_re), .b_im(b_im), .c_re(c_re), .c_im(c_im));
    neg_seq_overvoltage #(.TICK_CYCLES(10)) i_neg_seq_overvoltage (.mclk(mclk),
        .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .phase_a_re(a_re), .phase_a_im(a_im),
        .phase_b_re(b_re), .phase_b_im(b_im), .phase_c_re(c_re), .phase_c_im(c_im),
        .general_inhibit(general_inhibit), .first_stage_inhibit(first_stage_inhibit),
        .second_stage_inhibit(second_stage_inhibit),
        .measuring_circuit_fault(measuring_circuit_fault),
        .single_pole_open_inhibit(single_pole_open_inhibit),
        .stage_start_flag(stage_start_flag), .stage_trip_flag(stage_trip_flag),
        .stage_inhibited_flag(stage_inhibited_flag),
        .stage_operating_mode(stage_operating_mode), .health_alarm(health_alarm));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        // no cycle count assumed: a stalled slave is left to the watchdog
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic apply(input logic [15:0] v);
        @(posedge mclk);
        level <= v;
        repeat (6) @(posedge mclk);
    endtask
    // inhibit order: general, first, second, open pole, circuit fault
    task automatic hold_off(input logic [11:0] v, input logic [1:0] e);
        @(posedge mclk);
        {general_inhibit, first_stage_inhibit, second_stage_inhibit,
            single_pole_open_inhibit, measuring_circuit_fault} <= v;
        repeat (3) @(posedge mclk);
        check(stage_inhibited_flag, e);
        check(stage_start_flag, e ^ 2'b11);
        check(stage_operating_mode, {e[1] ? 2'h2 : 2'h1, e[0] ? 2'h2 : 2'h1});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_defaults;
        bus(0, nsov_pkg::REG_THR1, 0); check(rd, 32'h0000_00C8);
        bus(0, nsov_pkg::REG_DLY2, 0); check(rd, 32'h0000_03E8);
        bus(0, nsov_pkg::REG_TMS, 0); check(rd, 32'h0000_0064);
        bus(0, nsov_pkg::REG_CTRL, 0); check(rd, 32'h0000_0000);
        bus(0, 4'hC, 0); check(rd, 32'h0);
        check(health_alarm, 1'b1);
        bus(1, nsov_pkg::REG_CTRL, 32'h10);
        apply(16'h0FA0);
        check(health_alarm, 1'b0);
        check(stage_start_flag, 2'b00);
        check(stage_operating_mode, 4'h0);
        // sequence size equals the source level, within rounding
        bus(0, nsov_pkg::REG_MAG, 0);
        check(rd > 32'h0000_0F96 && rd < 32'h0000_0FAA, 1'b1);
    endtask
    task automatic s_definite;
        bus(1, nsov_pkg::REG_DLY1, 32'h3);
        bus(1, nsov_pkg::REG_CTRL, 32'h11);
        repeat (4) @(posedge mclk);
        check(stage_start_flag, 2'b01);
        check(stage_trip_flag, 2'b00);
        repeat (40) @(posedge mclk);
        check(stage_trip_flag, 2'b01);
        apply(16'h03E8);
        check({stage_start_flag, stage_trip_flag}, 4'h0);
        bus(1, nsov_pkg::REG_DLY1, 32'h0);
        apply(16'h0FA0);
        check(stage_trip_flag, 2'b01);
    endtask
    // 1930 lies between the threshold and 1.04 of it
    task automatic s_curve;
        // start from idle, else stage two picks up before the level drops
        apply(16'h03E8);
        bus(1, nsov_pkg::REG_CTRL, 32'h17);
        apply(16'd1930);
        check(stage_start_flag, 2'b01);
        apply(16'h0FA0);
        check(stage_start_flag, 2'b11);
        hold_off(12'h020, 2'b10);
        hold_off(12'h800, 2'b11);
        hold_off(12'h001, 2'b11);
        hold_off(12'h008, 2'b11);
        hold_off(12'h000, 2'b00);
        // trip expected near 897 ms at 4000 with a 1.0 multiplier
        repeat (8400) @(posedge mclk);
        check(stage_trip_flag[1], 1'b0);
        repeat (1000) @(posedge mclk);
        check(stage_trip_flag[1], 1'b1);
        bus(0, nsov_pkg::REG_STATUS, 0);
        check(rd, 32'h0000_000F);
        apply(16'd1800);
        check(stage_trip_flag, 2'b00);
    endtask
    // line phasors, then an unfit channel setting
    task automatic s_lines;
        bus(1, nsov_pkg::REG_CTRL, 32'h21);
        line_mode <= 1'b1;
        apply(16'h0FA0);
        bus(0, nsov_pkg::REG_MAG, 0);
        check(rd > 32'h0000_0F96 && rd < 32'h0000_0FAA, 1'b1);
        check(stage_trip_flag, 2'b01);
        bus(1, nsov_pkg::REG_CTRL, 32'h31);
        repeat (2) @(posedge mclk);
        check(health_alarm, 1'b1);
        check({stage_start_flag, stage_operating_mode}, 6'h02);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        s_defaults();
        s_definite();
        s_curve();
        s_lines();
        complete_run();
    end
    initial begin
        #1000000;
        failures++;
        complete_run();
    end
endmodule // neg_seq_overvoltage_test

/* nseq_source.sv */
/* phasor source standing in for the measurement front end
   gives a pure negative sequence set in sample units, as phase-earth
   phasors or, with line_mode high, as the line phasors ab and bc */
`timescale 1ns/100ps
module nseq_source (
    input wire logic [15:0] level, // wanted negative sequence size
    input wire logic line_mode, // high for line phasors
    output logic signed [15:0] a_re, // phase a or line ab real
    output logic signed [15:0] a_im, // phase a or line ab imaginary
    output logic signed [15:0] b_re, // phase b or line bc real
    output logic signed [15:0] b_im, // phase b or line bc imaginary
    output logic signed [15:0] c_re, // phase c real, zero in line mode
    output logic signed [15:0] c_im // phase c imaginary, zero in line mode
);
    logic signed [15:0] half, quad;
    // acb rotation: positive and zero sequence stay zero
    assign half = 16'(level >> 1);
    assign quad = 16'((int'(level) * 866) / 1000);
    assign a_re = line_mode ? 16'(level + half) : level;
    assign a_im = line_mode ? -quad : 16'sh0000;
    assign b_re = line_mode ? 16'sh0000 : -half;
    assign b_im = line_mode ? 16'(quad <<< 1) : quad;
    assign c_re = line_mode ? 16'sh0000 : -half;
    assign c_im = line_mode ? 16'sh0000 : -quad;
endmodule // nseq_source

/* nsov_pkg.sv */
/*
 * Constants, register map, field layout, reset values and enumerations
 * for the two-stage negative sequence overvoltage block.
 * Assumes a 25 MHz system clock and word addressing on the register bus.
 */
package nsov_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // register word indexes (byte offset is four times the index)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_RATED = 4'h1;
    localparam logic [3:0] REG_THR1 = 4'h2;
    localparam logic [3:0] REG_THR2 = 4'h3;
    localparam logic [3:0] REG_DLY1 = 4'h4;
    localparam logic [3:0] REG_DLY2 = 4'h5;
    localparam logic [3:0] REG_TMS = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_MAG = 4'h8;

    // control fields
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_CURVE_BIT = 2;
    localparam int CTRL_CFG_LSB = 4;

    // status fields
    localparam int STAT_START_LSB = 0;
    localparam int STAT_TRIP_LSB = 2;
    localparam int STAT_BLK_LSB = 4;
    localparam int STAT_ALARM_BIT = 8;

    // writable masks and reset values
    localparam logic [31:0] CTRL_MASK = 32'h0000_0037;
    localparam logic [31:0] RATED_MASK = 32'h0000_FFFF;
    localparam logic [31:0] THR_MASK = 32'h0000_0FFF;
    localparam logic [31:0] DLY_MASK = 32'h0007_FFFF;
    localparam logic [31:0] TMS_MASK = 32'h0000_07FF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] RATED_RESET = 32'h0000_4000;
    localparam logic [31:0] THR_RESET = 32'h0000_00C8;
    localparam logic [31:0] DLY_RESET = 32'h0000_03E8;
    localparam logic [31:0] TMS_RESET = 32'h0000_0064;

    ////////////////////////////////////////////////////////////////////////
    // fixed point scaling
    localparam logic [15:0] SEQ_K = 16'hDDB4;
    localparam logic [15:0] INV_SQRT3_K = 16'h93CD;
    localparam logic [15:0] UOP_K = 16'h9757;
    localparam int UOP_SHIFT = 26;
    localparam logic [22:0] INV_NUM = 23'h64_0000;
    localparam logic [43:0] INV_FULL = 44'h000_03E8_0000;
    localparam logic [4:0] DT_RESET_NUM = 5'h18;
    localparam logic [4:0] INV_PICK_NUM = 5'h1A;
    localparam logic [4:0] HYST_DEN = 5'h19;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        CFG_NONE = 2'b00,
        CFG_PHASE_EARTH = 2'b01,
        CFG_PHASE_PHASE = 2'b10,
        CFG_INVALID = 2'b11
    } chan_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PICKED = 2'b01,
        ST_TRIPPED = 2'b10
    } stage_state_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ON = 2'b01,
        MODE_BLOCKED = 2'b10
    } mode_t;

endpackage
